// ===== hw/ssm_pkg.sv
// ----------------------------------------------------------------
// State machine executor constants
// ----------------------------------------------------------------
package ssm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  // Longest application processing time per evaluation pass
  localparam int PROC_PERIOD_NS = 60000;
  // A longest time rounds down, never below one cycle
  localparam int PROC_CYCLES_RAW = PROC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PROC_CYCLES = (PROC_CYCLES_RAW < 1) ? 1 : PROC_CYCLES_RAW;
  localparam int PROC_CNT_W = $clog2(PROC_CYCLES + 1);

  // ----------------------------------------------------------------
  // Machine geometry defaults
  // ----------------------------------------------------------------
  localparam int MAX_STATES = 32;
  localparam int DEF_OUTPUTS = 8;
  localparam int DEF_VARIABLES = 4;
  localparam int DEF_INPUTS = 8;
  localparam int DEF_TRANSITIONS = 16;
  localparam int DEF_NEST_DEPTH = 4;
  localparam int DEF_FLASH_W = 24;
  localparam int DEF_WATCHDOG_W = 24;

  // ----------------------------------------------------------------
  // Signal value codes held per state and per machine default
  // ----------------------------------------------------------------
  localparam int VAL_W = 3;
  localparam logic [VAL_W-1:0] VAL_UNSET = 3'h0;
  localparam logic [VAL_W-1:0] VAL_FALSE = 3'h1;
  localparam logic [VAL_W-1:0] VAL_TRUE = 3'h2;
  localparam logic [VAL_W-1:0] VAL_FLASH = 3'h3;
  localparam logic [VAL_W-1:0] VAL_PASS = 3'h4;

  // ----------------------------------------------------------------
  // Execution control
  // ----------------------------------------------------------------
  typedef enum logic {
    RUN_IDLE,
    RUN_ACTIVE
  } ssm_run_t;

endpackage

// ===== hw/ssm_executor.sv
// Functional notes
// - Passthrough channel drives the latest host-written value.
// - While the host link is down, passthrough channels read false.
// - After link recovery, new host writes apply to passthrough channels.
// - Passthrough values skip transitions; running and a resolved passthrough code gate them.
// - A machine holds up to 32 states; encoding covers that count.
// - Active state keeps driving its values until a transition fires.
// - Start or compound entry activates the single designated initial state.
// - Compound states are nestable sub-machines of states and transitions.
// - Transition into a compound border activates its initial inner state.
// - Inner non-initial states are direct transition destinations.
// - Border transition exits compound whatever inner state is active.
// - Inner-state transition to outside destination leaves the compound.
// - Each output or variable is written by one machine only.
// - Nested assignments resolve to the innermost active state's value.
// - True energizes a channel, false de-energizes it.
// - Flash toggles the channel at a configurable interval.
// - Variables take assigned true or false and feed conditions.
// - User LED lit on true, dark on false, blinking on flash.
// - Unassigned signals take the machine-level default.
// - Inside a compound, unassigned signals take compound defaults.
// - Inputs sampled together; transitions checked in priority order.
`timescale 1ns/100ps

module ssm_executor
#(
  parameter int N_OUT = ssm_pkg::DEF_OUTPUTS,
  parameter int N_VAR = ssm_pkg::DEF_VARIABLES,
  parameter int N_IN = ssm_pkg::DEF_INPUTS,
  parameter int N_TRANS = ssm_pkg::DEF_TRANSITIONS,
  parameter int DEPTH = ssm_pkg::DEF_NEST_DEPTH,
  parameter int FLASH_W = ssm_pkg::DEF_FLASH_W,
  parameter int WD_W = ssm_pkg::DEF_WATCHDOG_W,
  parameter int SW = $clog2(ssm_pkg::MAX_STATES),
  parameter int NSIG = N_OUT + N_VAR + 1,
  parameter int VW = NSIG * ssm_pkg::VAL_W,
  parameter int NC = N_IN + N_VAR
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [N_IN-1:0] field_in,
  input wire logic cfg_state_we,
  input wire logic [SW-1:0] cfg_state_idx,
  input wire logic [SW-1:0] cfg_state_parent,
  input wire logic cfg_state_nested,
  input wire logic cfg_state_compound,
  input wire logic [SW-1:0] cfg_state_initial,
  input wire logic [VW-1:0] cfg_state_values,
  input wire logic cfg_trans_we,
  input wire logic [$clog2(N_TRANS)-1:0] cfg_trans_idx,
  input wire logic cfg_trans_valid,
  input wire logic [SW-1:0] cfg_trans_src,
  input wire logic [SW-1:0] cfg_trans_dst,
  input wire logic [NC-1:0] cfg_trans_mask,
  input wire logic [NC-1:0] cfg_trans_invert,
  input wire logic cfg_top_we,
  input wire logic [SW-1:0] cfg_top_initial,
  input wire logic [VW-1:0] cfg_top_defaults,
  input wire logic [FLASH_W-1:0] flash_half_period,
  input wire logic [WD_W-1:0] watchdog_period,
  input wire logic host_we,
  input wire logic [N_OUT-1:0] host_value,
  output logic [N_OUT-1:0] out_energize,
  output logic [N_VAR-1:0] var_value,
  output logic user_indicator_led,
  output logic [SW-1:0] active_state,
  output logic link_up,
  output logic running
);

  localparam int VL = ssm_pkg::VAL_W;
  localparam int NS = ssm_pkg::MAX_STATES;

  // ----------------------------------------------------------------
  // Program tables
  // ----------------------------------------------------------------
  logic [SW-1:0] st_parent [NS];
  logic st_nested [NS];
  logic st_compound [NS];
  logic [SW-1:0] st_initial [NS];
  logic [VW-1:0] st_values [NS];
  logic tr_valid [N_TRANS];
  logic [SW-1:0] tr_src [N_TRANS];
  logic [SW-1:0] tr_dst [N_TRANS];
  logic [NC-1:0] tr_mask [N_TRANS];
  logic [NC-1:0] tr_invert [N_TRANS];
  logic [SW-1:0] top_initial;
  logic [VW-1:0] top_defaults;

  // Tables are only rewritten by the loader; a reloaded transition takes effect
  // at the next evaluation pass, reloaded state values on the next clock.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NS; i++)
      begin
        st_parent[i] <= '0;
        st_nested[i] <= 1'b0;
        st_compound[i] <= 1'b0;
        st_initial[i] <= '0;
        st_values[i] <= '0;
      end
    end
    else if (cfg_state_we)
    begin
      st_parent[cfg_state_idx] <= cfg_state_parent;
      st_nested[cfg_state_idx] <= cfg_state_nested;
      st_compound[cfg_state_idx] <= cfg_state_compound;
      st_initial[cfg_state_idx] <= cfg_state_initial;
      st_values[cfg_state_idx] <= cfg_state_values;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < N_TRANS; i++)
      begin
        tr_valid[i] <= 1'b0;
        tr_src[i] <= '0;
        tr_dst[i] <= '0;
        tr_mask[i] <= '0;
        tr_invert[i] <= '0;
      end
    end
    else if (cfg_trans_we)
    begin
      tr_valid[cfg_trans_idx] <= cfg_trans_valid;
      tr_src[cfg_trans_idx] <= cfg_trans_src;
      tr_dst[cfg_trans_idx] <= cfg_trans_dst;
      tr_mask[cfg_trans_idx] <= cfg_trans_mask;
      tr_invert[cfg_trans_idx] <= cfg_trans_invert;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      top_initial <= '0;
      top_defaults <= '0;
    end
    else if (cfg_top_we)
    begin
      top_initial <= cfg_top_initial;
      top_defaults <= cfg_top_defaults;
    end
  end

  // ----------------------------------------------------------------
  // Input synchroniser and processing cycle
  // ----------------------------------------------------------------
  logic [N_IN-1:0] in_meta;
  logic [N_IN-1:0] in_sync;
  logic [ssm_pkg::PROC_CNT_W-1:0] proc_cnt;
  logic proc_tick;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      in_meta <= '0;
      in_sync <= '0;
    end
    else
    begin
      in_meta <= field_in;
      in_sync <= in_meta;
    end
  end

  assign proc_tick = (proc_cnt ==
    ssm_pkg::PROC_CNT_W'(ssm_pkg::PROC_CYCLES - 1));

  always_ff @(posedge ref_clk)
  begin
    if (reset || proc_tick)
      proc_cnt <= '0;
    else
      proc_cnt <= proc_cnt + 1'b1;
  end

  // ----------------------------------------------------------------
  // Active path: leaf state and its enclosing compounds
  // ----------------------------------------------------------------
  ssm_pkg::ssm_run_t run_state;
  logic [SW-1:0] leaf;
  logic [SW-1:0] anc [DEPTH];
  logic anc_ok [DEPTH];

  assign anc[0] = leaf;
  assign anc_ok[0] = (run_state == ssm_pkg::RUN_ACTIVE);

  generate
    for (genvar d = 1; d < DEPTH; d++)
    begin : g_anc
      assign anc[d] = st_parent[anc[d-1]];
      assign anc_ok[d] = anc_ok[d-1] && st_nested[anc[d-1]];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Transition evaluation
  // ----------------------------------------------------------------
  logic [NC-1:0] cond_vec;
  logic [N_TRANS-1:0] tr_fire;
  logic fire_any;
  logic [SW-1:0] fire_dst;

  // Inputs and variables are read as one snapshot at the tick edge
  assign cond_vec = {var_value, in_sync};

  generate
    for (genvar t = 0; t < N_TRANS; t++)
    begin : g_trans
      logic src_active;
      logic cond_true;
      // A border source matches any active ancestor, so the exit
      // happens whatever inner state is current
      always_comb
      begin
        src_active = 1'b0;
        for (int d = 0; d < DEPTH; d++)
          if (anc_ok[d] && anc[d] == tr_src[t])
            src_active = 1'b1;
      end
      assign cond_true = &((cond_vec ^ tr_invert[t]) | ~tr_mask[t]);
      assign tr_fire[t] = tr_valid[t] && src_active && cond_true;
    end
  endgenerate

  // Lowest table index is highest priority
  always_comb
  begin
    fire_any = 1'b0;
    fire_dst = '0;
    for (int t = N_TRANS - 1; t >= 0; t--)
    begin
      if (tr_fire[t])
      begin
        fire_any = 1'b1;
        fire_dst = tr_dst[t];
      end
    end
  end

  // ----------------------------------------------------------------
  // Entry descent: compounds resolve to their initial leaf
  // ----------------------------------------------------------------
  logic [SW-1:0] dsc [DEPTH+1];

  assign dsc[0] = (run_state == ssm_pkg::RUN_IDLE) ? top_initial
                                                   : fire_dst;

  generate
    for (genvar d = 0; d < DEPTH; d++)
    begin : g_dsc
      // A simple destination stays put, reached directly
      assign dsc[d+1] = st_compound[dsc[d]] ? st_initial[dsc[d]]
                                            : dsc[d];
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (reset || !run)
    begin
      run_state <= ssm_pkg::RUN_IDLE;
      leaf <= '0;
    end
    else
    begin
      case (run_state)
        ssm_pkg::RUN_IDLE:
        begin
          run_state <= ssm_pkg::RUN_ACTIVE;
          leaf <= dsc[DEPTH];
        end
        ssm_pkg::RUN_ACTIVE:
          if (proc_tick && fire_any)
            leaf <= dsc[DEPTH];
        default:
          run_state <= ssm_pkg::RUN_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Signal resolution: innermost assignment wins
  // ----------------------------------------------------------------
  logic [VL-1:0] sig_code [NSIG];
  logic [VL-1:0] code_q [NSIG];

  generate
    for (genvar s = 0; s < NSIG; s++)
    begin : g_res
      always_comb
      begin
        sig_code[s] = top_defaults[s*VL +: VL];
        for (int d = DEPTH - 1; d >= 0; d--)
          if (anc_ok[d] &&
              st_values[anc[d]][s*VL +: VL] != ssm_pkg::VAL_UNSET)
            sig_code[s] = st_values[anc[d]][s*VL +: VL];
      end
      // All codes change together, one clock after the leaf moves
      always_ff @(posedge ref_clk)
      begin
        if (reset)
          code_q[s] <= ssm_pkg::VAL_UNSET;
        else
          code_q[s] <= sig_code[s];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flash phase
  // ----------------------------------------------------------------
  logic [FLASH_W-1:0] flash_cnt;
  logic flash_phase;
  logic flash_wrap;

  assign flash_wrap = (flash_cnt + 1'b1 >= flash_half_period);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      flash_cnt <= '0;
      flash_phase <= 1'b0;
    end
    else if (flash_wrap)
    begin
      flash_cnt <= '0;
      flash_phase <= !flash_phase;
    end
    else
      flash_cnt <= flash_cnt + 1'b1;
  end

  // ----------------------------------------------------------------
  // Host link watchdog and passthrough values
  // ----------------------------------------------------------------
  logic [WD_W-1:0] wd_cnt;
  logic [N_OUT-1:0] pass_val;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wd_cnt <= '0;
      link_up <= 1'b0;
    end
    else if (host_we)
    begin
      wd_cnt <= '0;
      link_up <= 1'b1;
    end
    else if (link_up)
    begin
      wd_cnt <= wd_cnt + 1'b1;
      if (wd_cnt + 1'b1 >= watchdog_period)
        link_up <= 1'b0;
    end
  end

  // Stale values are dropped on loss so they cannot reappear later
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pass_val <= '0;
    else if (host_we)
      pass_val <= host_value;
    else if (!link_up)
      pass_val <= '0;
  end

  // ----------------------------------------------------------------
  // Output drivers: one machine owns every signal
  // ----------------------------------------------------------------
  generate
    for (genvar c = 0; c < N_OUT; c++)
    begin : g_out
      logic next_out;
      // Passthrough is not tied to the processing tick, only to the resolved state code, link_up and running
      assign next_out =
        (code_q[c] == ssm_pkg::VAL_TRUE) ? 1'b1 :
        (code_q[c] == ssm_pkg::VAL_FLASH) ? flash_phase :
        (code_q[c] == ssm_pkg::VAL_PASS) ? pass_val[c] && link_up :
        1'b0;
      always_ff @(posedge ref_clk)
      begin
        if (reset)
          out_energize[c] <= 1'b0;
        else
          out_energize[c] <= running && next_out;
      end
    end
    for (genvar v = 0; v < N_VAR; v++)
    begin : g_var
      always_ff @(posedge ref_clk)
      begin
        if (reset)
          var_value[v] <= 1'b0;
        else
          var_value[v] <= running &&
            (code_q[N_OUT+v] == ssm_pkg::VAL_TRUE);
      end
    end
  endgenerate

  logic [VL-1:0] led_code;
  logic next_led;

  assign led_code = code_q[NSIG-1];
  assign next_led = (led_code == ssm_pkg::VAL_TRUE) ||
    ((led_code == ssm_pkg::VAL_FLASH) && flash_phase);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      user_indicator_led <= 1'b0;
      running <= 1'b0;
      active_state <= '0;
    end
    else
    begin
      user_indicator_led <= running && next_led;
      running <= (run_state == ssm_pkg::RUN_ACTIVE);
      active_state <= leaf;
    end
  end

endmodule

// ===== verification/ssm_executor_checker.sv
`timescale 1ns/100ps
module ssm_executor_checker
#(
  parameter int N_OUT = 8,
  parameter int N_VAR = 4,
  parameter int WD_W = 24,
  parameter int SW = 5
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic host_we,
  input wire logic [WD_W-1:0] watchdog_period,
  input wire logic [N_OUT-1:0] out_energize,
  input wire logic [N_VAR-1:0] var_value,
  input wire logic user_indicator_led,
  input wire logic [SW-1:0] active_state,
  input wire logic link_up,
  input wire logic running
);
  logic [31:0] idle_cnt;
  logic [15:0] since_move;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge ref_clk)
  begin
    if (reset || host_we)
      idle_cnt <= 32'h0;
    else
      idle_cnt <= idle_cnt + 32'h1;
  end
  // Saturates, so the first move after a start is never flagged
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      since_move <= 16'hffff;
    else if (running && $past(running) && $changed(active_state))
      since_move <= 16'h0;
    else if (since_move != 16'hffff)
      since_move <= since_move + 16'h1;
  end
  // Run is seen one edge, running is registered the edge after
  run_follow_a: assert property (run |-> ##2 running)
    else $error("running did not follow run");
  // Outputs are gated by running, so they clear one edge after it
  idle_clear_a: assert property (!run |-> ##2 !running ##1
    (out_energize == '0 && var_value == '0 && !user_indicator_led))
    else $error("outputs not cleared after stop");
  start_cause_a: assert property ($rose(running) |-> $past(run, 2))
    else $error("running rose without run");
  reset_clear_a: assert property ($fell(reset) |->
    !link_up && !running && out_energize == '0)
    else $error("outputs not clear after reset");
  link_kick_a: assert property (
    host_we && watchdog_period != '0 |=> link_up)
    else $error("write did not raise link");
  link_cause_a: assert property ($rose(link_up) |-> $past(host_we))
    else $error("link rose without write");
  link_loss_a: assert property (
    idle_cnt > 32'(watchdog_period) + 32'h3 |-> !link_up)
    else $error("link held past watchdog period");
  state_hold_a: assert property (
    running && $past(running) && $changed(active_state) |->
    since_move >= 16'hbae)
    else $error("state moved between evaluation ticks");
  cover property ($rose(running));
  cover property ($fell(link_up));
  cover property (running && $changed(active_state));
endmodule

bind ssm_executor ssm_executor_checker
  #(.N_OUT(N_OUT), .N_VAR(N_VAR), .WD_W(WD_W), .SW(SW)) u_checker (
  .ref_clk, .reset, .run, .host_we, .watchdog_period, .out_energize,
  .var_value, .user_indicator_led, .active_state, .link_up, .running);

// ===== verification/ssm_host_model.sv
`timescale 1ns/100ps
module ssm_host_model
#(
  parameter int N = 8,
  parameter int GAP = 10
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [N-1:0] value,
  output logic host_we = 1'b0,
  output logic [N-1:0] host_value = '0
);
  int cnt = 0;
  logic due;
  assign due = !reset && enable && cnt >= GAP;
  // Between writes the data lines carry junk, never the last value
  always @(posedge ref_clk)
  begin
    host_we <= due;
    host_value <= due ? value : ~value;
    cnt <= (reset || !enable || cnt >= GAP) ? 0 : cnt + 1;
  end
endmodule

// ===== verification/safety_state_machine_outputs_tb_top.sv
`timescale 1ns/100ps
module safety_state_machine_outputs_tb_top;
  localparam logic [2:0] VF = ssm_pkg::VAL_FALSE;
  localparam logic [2:0] VT = ssm_pkg::VAL_TRUE;
  localparam logic [2:0] VL = ssm_pkg::VAL_FLASH;
  localparam logic [2:0] VP = ssm_pkg::VAL_PASS;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic host_en = 1'b0;
  logic cfg_state_we, cfg_state_nested, cfg_state_compound, cfg_trans_we;
  logic cfg_trans_valid, cfg_top_we, host_we, user_indicator_led;
  logic link_up, running;
  logic [4:0] cfg_state_idx, cfg_state_parent, cfg_state_initial;
  logic [4:0] cfg_trans_src, cfg_trans_dst, cfg_top_initial, active_state;
  logic [38:0] cfg_state_values, cfg_top_defaults;
  logic [3:0] cfg_trans_idx, var_value;
  logic [11:0] cfg_trans_mask, cfg_trans_invert;
  logic [7:0] field_in, host_value, host_val, out_energize;
  logic [23:0] flash_half_period = 24'h4;
  logic [23:0] watchdog_period = 24'h32;
  int num_errors = 0;
  int n_compared = 0;

  ssm_executor dut (.ref_clk, .reset, .run, .field_in, .cfg_state_we,
    .cfg_state_idx, .cfg_state_parent, .cfg_state_nested,
    .cfg_state_compound, .cfg_state_initial, .cfg_state_values,
    .cfg_trans_we, .cfg_trans_idx, .cfg_trans_valid, .cfg_trans_src,
    .cfg_trans_dst, .cfg_trans_mask, .cfg_trans_invert, .cfg_top_we,
    .cfg_top_initial, .cfg_top_defaults, .flash_half_period,
    .watchdog_period, .host_we, .host_value, .out_energize, .var_value,
    .user_indicator_led, .active_state, .link_up, .running);
  ssm_host_model #(.N(8), .GAP(10)) host (.ref_clk, .reset,
    .enable(host_en), .value(host_val), .host_we, .host_value);
  always #10 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic logic [38:0] sv(input int s, input logic [2:0] c);
    return 39'(c) << (3 * s);
  endfunction

  task automatic put_state(input logic [4:0] idx, par, init,
    input logic nst, cmp, input logic [38:0] vals);
    @(negedge ref_clk);
    cfg_state_we = 1'b1;
    {cfg_state_idx, cfg_state_parent, cfg_state_initial} = {idx, par, init};
    {cfg_state_nested, cfg_state_compound} = {nst, cmp};
    cfg_state_values = vals;
    @(negedge ref_clk);
    cfg_state_we = 1'b0;
  endtask

  task automatic put_trans(input logic [3:0] idx, input logic [4:0] src, dst,
    input int bit_no);
    @(negedge ref_clk);
    {cfg_trans_we, cfg_trans_valid} = 2'h3;
    {cfg_trans_idx, cfg_trans_src, cfg_trans_dst} = {idx, src, dst};
    cfg_trans_mask = 12'h1 << bit_no;
    @(negedge ref_clk);
    cfg_trans_we = 1'b0;
  endtask

  task automatic test_start;
    logic f0;
    check("link at reset", link_up, 1'b0);
    @(negedge ref_clk);
    cfg_top_we = 1'b1;
    cfg_top_initial = 5'h1;
    for (int s = 0; s < 13; s++)
      cfg_top_defaults |= sv(s, VF);
    @(negedge ref_clk);
    cfg_top_we = 1'b0;
    put_state(5'h1, 5'h0, 5'h0, 1'b0, 1'b0,
      sv(0, VT) | sv(1, VP) | sv(2, VL) | sv(8, VT) | sv(12, VT));
    put_state(5'h2, 5'h0, 5'h3, 1'b0, 1'b1, sv(3, VT) | sv(5, VT));
    put_state(5'h3, 5'h2, 5'h0, 1'b1, 1'b0, sv(3, VF) | sv(4, VT));
    put_state(5'h4, 5'h2, 5'h0, 1'b1, 1'b0, sv(6, VT));
    put_trans(4'h0, 5'h1, 5'h2, 0);
    put_trans(4'h1, 5'h3, 5'h4, 1);
    put_trans(4'h2, 5'h2, 5'h1, 2);
    put_trans(4'h3, 5'h1, 5'h4, 3);
    put_trans(4'h4, 5'h3, 5'h1, 4);
    // Leaves state 4 whenever the first variable reads false
    cfg_trans_invert = 12'h100;
    put_trans(4'h5, 5'h4, 5'h3, 8);
    cfg_trans_invert = 12'h0;
    run = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("start state", active_state, 5'h1);
    check("state outs", out_energize & 8'hf9, 8'h01);
    check("pass link down", out_energize[1], 1'b0);
    check("vars", var_value, 4'h1);
    check("led", user_indicator_led, 1'b1);
    check("running", running, 1'b1);
    f0 = out_energize[2];
    repeat (4) @(negedge ref_clk);
    check("flash half", out_energize[2], !f0);
    repeat (4) @(negedge ref_clk);
    check("flash full", out_energize[2], f0);
    $display("test_start done");
  endtask

  task automatic test_pass;
    host_val = 8'h82;
    host_en = 1'b1;
    repeat (40) @(negedge ref_clk);
    check("link up", link_up, 1'b1);
    check("pass set", out_energize[1], 1'b1);
    check("other chan", out_energize[7], 1'b0);
    host_val = 8'h02;
    host_en = 1'b0;
    repeat (80) @(negedge ref_clk);
    check("link lost", link_up, 1'b0);
    check("pass on loss", out_energize[1], 1'b0);
    host_en = 1'b1;
    repeat (40) @(negedge ref_clk);
    check("pass restored", out_energize[1], 1'b1);
    host_val = 8'h00;
    repeat (30) @(negedge ref_clk);
    check("pass clear", out_energize[1], 1'b0);
    $display("test_pass done");
  endtask

  // Each step waits for the next evaluation tick, about 3000 clocks away
  task automatic test_moves;
    logic [7:0] fin [8] = '{8'h09, 8'h02, 8'h04, 8'h08, 8'h00, 8'h04,
      8'h01, 8'h10};
    logic [4:0] nxt [8] = '{5'h3, 5'h4, 5'h1, 5'h4, 5'h3, 5'h1, 5'h3, 5'h1};
    logic [7:0] outs [8] = '{8'h30, 8'h68, 8'h01, 8'h68, 8'h30, 8'h01,
      8'h30, 8'h01};
    logic [4:0] old;
    for (int i = 0; i < 8; i++)
    begin
      old = active_state;
      field_in = fin[i];
      for (int k = 0; k < 3200 && active_state === old; k++)
        @(negedge ref_clk);
      repeat (3) @(negedge ref_clk);
      field_in = 8'h0;
      check("next state", active_state, nxt[i]);
      check("resolved outs", out_energize & 8'hf9, outs[i]);
    end
    run = 1'b0;
    repeat (3) @(negedge ref_clk);
    check("stop outs", out_energize, 8'h0);
    check("stop running", running, 1'b0);
    $display("test_moves done");
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    {cfg_state_we, cfg_state_nested, cfg_state_compound, cfg_trans_we} = '0;
    {cfg_trans_valid, cfg_top_we, cfg_state_idx, cfg_state_parent} = '0;
    {cfg_state_initial, cfg_trans_src, cfg_trans_dst, cfg_top_initial} = '0;
    {cfg_state_values, cfg_top_defaults, cfg_trans_idx, host_val} = '0;
    {cfg_trans_mask, cfg_trans_invert, field_in} = '0;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    test_start;
    test_pass;
    test_moves;
    final_report;
  end

  initial
  begin
    #800000;
    num_errors++;
    $display("[FAIL] run length expected finish seen timeout");
    final_report;
  end
endmodule
